//--- src/csm_chip_select.v
// chip select configuration bank with address decode and access timing
// assumes a synchronous byte register port and a one-cycle access start pulse
//
// Summary of operation
// - wait field inserts its value as wait states
// - type bit picks memory or I/O space
// - enable bit turns the select on
// - reset loads E8h select 0, 00h others
// - mode field picks one of four protocols
// - non-native protocol ignores wait field
// - mux bit puts address onto data bus
// - each protocol state lasts length-field clocks
// - length field ignored in native mode
// - memory select hits within lower..upper bounds
// - I/O select hits on lower bound match
// - switch to strobe protocols adds one clock
`timescale 1ns/10ps
`default_nettype none
`include "csm_regs.vh"

module csm_chip_select #(
  parameter NUM_SEL    = 4,
  parameter PROT_STATES = 4
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWrEn,
  input  wire        regRdEn,
  output reg  [7:0]  regRdData,
  input  wire [23:0] busAddr,
  input  wire        memReq,
  input  wire        ioReq,
  input  wire        accessStart,
  output reg  [3:0]  selectActive_n,
  output reg  [1:0]  accessMode,
  output reg         sharedAddrData,
  output wire        accessBusy
);

  // ----------------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------------
  reg [7:0] ctl_r [0:3];
  reg [7:0] pro_r [0:3];
  reg [7:0] lb_r  [0:3];
  reg [7:0] ub_r  [0:3];
  reg [1:0] lastMode_r;
  integer   i;
  integer   j;
  // states per non-native access, sized for the count arithmetic
  localparam [7:0] PROT_N = PROT_STATES;

  // index of a register address within a group of four, or 4 on miss
  function [2:0] grpIdx;
    input [7:0] a;
    input [7:0] a0;
    input [7:0] a1;
    input [7:0] a2;
    input [7:0] a3;
    begin
      if (a == a0) grpIdx = 3'd0;
      else if (a == a1) grpIdx = 3'd1;
      else if (a == a2) grpIdx = 3'd2;
      else if (a == a3) grpIdx = 3'd3;
      else grpIdx = 3'd4;
    end
  endfunction

  wire [2:0] ctlIdx = grpIdx(regAddr, `CSM_CTL0_ADDR, `CSM_CTL1_ADDR, `CSM_CTL2_ADDR, `CSM_CTL3_ADDR);
  wire [2:0] proIdx = grpIdx(regAddr, `CSM_PRO0_ADDR, `CSM_PRO1_ADDR, `CSM_PRO2_ADDR, `CSM_PRO3_ADDR);
  wire [2:0] lbIdx  = grpIdx(regAddr, `CSM_LB0_ADDR, `CSM_LB1_ADDR, `CSM_LB2_ADDR, `CSM_LB3_ADDR);
  wire [2:0] ubIdx  = grpIdx(regAddr, `CSM_UB0_ADDR, `CSM_UB1_ADDR, `CSM_UB2_ADDR, `CSM_UB3_ADDR);

  // ----------------------------------------------------------------------------
  // register writes; reserved bits masked so they stay zero
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r[0] <= `CSM_CTL0_RST;
      ub_r[0]  <= `CSM_UB0_RST;
      for (i = 1; i < 4; i = i + 1) begin
        ctl_r[i] <= `CSM_CTL_RST;
        ub_r[i]  <= `CSM_UB_RST;
      end
      for (i = 0; i < 4; i = i + 1) begin
        pro_r[i] <= `CSM_PRO_RST;
        lb_r[i]  <= `CSM_LB_RST;
      end
    end else if (regWrEn) begin
      if (ctlIdx[2] == 1'b0) begin
        ctl_r[ctlIdx[1:0]] <= regWrData & `CSM_CTL_WMASK;
      end
      if (proIdx[2] == 1'b0) begin
        pro_r[proIdx[1:0]] <= regWrData & `CSM_PRO_WMASK;
      end
      if (lbIdx[2] == 1'b0) begin
        lb_r[lbIdx[1:0]] <= regWrData;
      end
      if (ubIdx[2] == 1'b0) begin
        ub_r[ubIdx[1:0]] <= regWrData;
      end
    end
  end

  // read data, registered one cycle after the strobe; unmapped reads zero
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= `CSM_ZERO8;
    end else if (regRdEn) begin
      if (ctlIdx[2] == 1'b0) regRdData <= ctl_r[ctlIdx[1:0]];
      else if (proIdx[2] == 1'b0) regRdData <= pro_r[proIdx[1:0]];
      else if (lbIdx[2] == 1'b0) regRdData <= lb_r[lbIdx[1:0]];
      else if (ubIdx[2] == 1'b0) regRdData <= ub_r[ubIdx[1:0]];
      else regRdData <= `CSM_ZERO8;
    end else begin
      regRdData <= `CSM_ZERO8;
    end
  end

  // ----------------------------------------------------------------------------
  // address decode; lowest select wins on overlap
  // ----------------------------------------------------------------------------
  reg [3:0] hit;
  reg [1:0] selIdx;
  reg       anyHit;
  always @* begin
    hit    = 4'h0;
    selIdx = 2'h0;
    anyHit = 1'b0;
    for (j = 0; j < 4; j = j + 1) begin
      if (ctl_r[j][`CSM_EN_BIT]) begin
        if (ctl_r[j][`CSM_IO_BIT]) begin
          hit[j] = ioReq && (busAddr[15:8] == lb_r[j]);
        end else begin
          hit[j] = memReq && (busAddr[23:16] >= lb_r[j]) && (busAddr[23:16] <= ub_r[j]);
        end
      end
    end
    for (j = 3; j >= 0; j = j - 1) begin
      if (hit[j]) begin
        selIdx = j[1:0];
        anyHit = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // access length for the decoded select
  // ----------------------------------------------------------------------------
  wire [7:0] selCtl  = ctl_r[selIdx];
  wire [7:0] selPro  = pro_r[selIdx];
  wire [1:0] selMode = selPro[`CSM_MODE_HI:`CSM_MODE_LO];
  wire [3:0] selLen  = selPro[`CSM_LEN_HI:`CSM_LEN_LO];
  wire [2:0] selWait = selCtl[`CSM_WAIT_HI:`CSM_WAIT_LO];
  wire       strobeSwitch = ((selMode == `CSM_MODE_ALT2) || (selMode == `CSM_MODE_ALT3)) &&
                            (lastMode_r != selMode);
  reg  [7:0] loadCount;
  always @* begin
    if (selMode == `CSM_MODE_NATIVE) begin
      loadCount = {5'h00, selWait};
    end else begin
      // wait field ignored; each protocol state spans selLen clocks
      loadCount = {4'h0, selLen} * PROT_N + {7'h00, strobeSwitch};
    end
  end

  wire startAcc = accessStart && anyHit && !accessBusy;

  csm_access_timer #(
    .CNT_W(8)
  ) u_timer (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .start    (startAcc),
    .loadCount(loadCount),
    .busy     (accessBusy)
  );

  // ----------------------------------------------------------------------------
  // select outputs and per-access protocol state
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      selectActive_n <= 4'hF;
      accessMode     <= `CSM_MODE_NATIVE;
      sharedAddrData <= 1'b0;
      lastMode_r     <= `CSM_MODE_NATIVE;
    end else begin
      selectActive_n <= ~hit; // every hitting select, low true
      if (startAcc) begin
        accessMode     <= selMode;
        sharedAddrData <= selPro[`CSM_MUX_BIT];
        lastMode_r     <= selMode;
      end
    end
  end

endmodule
`default_nettype wire

//--- include/csm_regs.vh
// chip select configuration: register offsets, fields, reset values
// assumes byte-wide registers reached over a plain strobe port
`ifndef CSM_REGS_VH
`define CSM_REGS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define CSM_ADDR_W        8
`define CSM_CTL0_ADDR     8'hAA
`define CSM_CTL1_ADDR     8'hAD
`define CSM_CTL2_ADDR     8'hB0
`define CSM_CTL3_ADDR     8'hB3
`define CSM_PRO0_ADDR     8'hF0
`define CSM_PRO1_ADDR     8'hF1
`define CSM_PRO2_ADDR     8'hF2
`define CSM_PRO3_ADDR     8'hF3
`define CSM_LB0_ADDR      8'hA8
`define CSM_LB1_ADDR      8'hAB
`define CSM_LB2_ADDR      8'hAE
`define CSM_LB3_ADDR      8'hB1
`define CSM_UB0_ADDR      8'hA9
`define CSM_UB1_ADDR      8'hAC
`define CSM_UB2_ADDR      8'hAF
`define CSM_UB3_ADDR      8'hB2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CSM_CTL0_RST      8'hE8
`define CSM_CTL_RST       8'h00
`define CSM_PRO_RST       8'h02
`define CSM_LB_RST        8'h00
`define CSM_UB0_RST       8'hFF
`define CSM_UB_RST        8'h00

// ----------------------------------------------------------------------------
// fields and masks
// ----------------------------------------------------------------------------
`define CSM_CTL_WMASK     8'hF8
`define CSM_PRO_WMASK     8'hEF
`define CSM_WAIT_HI       7
`define CSM_WAIT_LO       5
`define CSM_IO_BIT        4
`define CSM_EN_BIT        3
`define CSM_MODE_HI       7
`define CSM_MODE_LO       6
`define CSM_MUX_BIT       5
`define CSM_LEN_HI        3
`define CSM_LEN_LO        0
`define CSM_MODE_NATIVE   2'h0
`define CSM_MODE_ALT1     2'h1
`define CSM_MODE_ALT2     2'h2
`define CSM_MODE_ALT3     2'h3
`define CSM_ZERO8         8'h00
`define CSM_ZERO4         4'h0
`define CSM_ONE4          4'h1
`define CSM_ONE3          3'h1

`endif

//--- src/csm_access_timer.v
// access timer: counts wait states or protocol state clocks for one access
// assumes start is a one-cycle pulse from the decoder while the timer is idle
`timescale 1ns/10ps
`default_nettype none
`include "csm_regs.vh"

module csm_access_timer #(
  parameter CNT_W = 8
) (
  input  wire             ref_clk,
  input  wire             rst_n,
  input  wire             start,
  input  wire [CNT_W-1:0] loadCount,
  output wire             busy
);

  reg [CNT_W-1:0] count_r;
  reg [CNT_W-1:0] count_nxt;

  // ----------------------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------------------
  always @* begin
    count_nxt = count_r;
    if (start) begin
      count_nxt = loadCount;
    end else if (count_r != {CNT_W{1'b0}}) begin
      count_nxt = count_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // count register
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= {CNT_W{1'b0}};
    end else begin
      count_r <= count_nxt;
    end
  end

  assign busy = (count_r != {CNT_W{1'b0}});

endmodule
`default_nettype wire

//--- verif/csm_chip_select_chk.sv
// checker: register port and access timing relations
// assumes bind onto csm_chip_select, one clock domain
`timescale 1ns/10ps
`default_nettype none
module csm_chip_select_chk #(parameter PROT_STATES = 4) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData,
  input wire logic [23:0] busAddr,
  input wire logic        memReq,
  input wire logic        ioReq,
  input wire logic        accessStart,
  input wire logic [3:0]  selectActive_n,
  input wire logic [1:0]  accessMode,
  input wire logic        sharedAddrData,
  input wire logic        accessBusy
);
  // ----------------
  // helpers
  // ----------------
  logic [7:0] busyCnt_r;
  // length of the current busy run
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) busyCnt_r <= 8'h00;
    else busyCnt_r <= accessBusy ? busyCnt_r + 8'h01 : 8'h00;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence wrCtl1; regWrEn && regAddr == 8'hAD; endsequence
  sequence rdCtl1; regRdEn && regAddr == 8'hAD; endsequence
  // ----------------
  // assertions
  // ----------------
  a_ctl_rdback: assert property (wrCtl1 ##2 rdCtl1 |=> regRdData == ($past(regWrData, 3) & 8'hF8))
    else $error("control readback wrong");
  a_ctl_resv: assert property (regRdEn && regAddr == 8'hAA |=> regRdData[2:0] == 3'h0)
    else $error("control reserved bits set");
  a_pro_resv: assert property (regRdEn && regAddr[7:2] == 6'h3C |=> !regRdData[4])
    else $error("protocol reserved bit set");
  a_mode_cause: assert property ($changed(accessMode) |-> $past(accessStart))
    else $error("mode changed without access");
  a_mux_cause: assert property ($changed(sharedAddrData) |-> $past(accessStart))
    else $error("mux changed without access");
  a_idle_nosel: assert property (!memReq && !ioReq |=> selectActive_n == 4'hF)
    else $error("select without request");
  a_busy_cause: assert property ($rose(accessBusy) |-> $past(accessStart))
    else $error("busy without start");
  a_busy_bound: assert property (busyCnt_r <= 15 * PROT_STATES + 1)
    else $error("busy too long");
endmodule
bind csm_chip_select csm_chip_select_chk #(.PROT_STATES(PROT_STATES)) chk_u (.*);
`default_nettype wire

//--- verif/csm_ext_dev.sv
// far side model: devices behind the four select lines
// assumes active-low selects seen on the system clock
`timescale 1ns/10ps
`default_nettype none
module csm_ext_dev (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] selectActive_n,
  output var  logic [3:0] seenSel
);
  // remembers every device that was selected
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) seenSel <= 4'h0;
    else seenSel <= seenSel | ~selectActive_n;
endmodule
`default_nettype wire

//--- verif/csm_chip_select_test.sv
// testbench: register port, decode and access timing
// assumes csm_chip_select with its checker bound in
`timescale 1ns/10ps
`default_nettype none
`include "csm_regs.vh"
module csm_chip_select_test;
  logic        ref_clk = 1'b0, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
  logic        memReq = 1'b0, ioReq = 1'b0, accessStart = 1'b0, sReq = 1'b0;
  logic        rdP = 1'b0, sP = 1'b0, sharedAddrData, accessBusy;
  logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData, d;
  logic [23:0] busAddr = 24'h000000;
  logic [3:0]  selectActive_n, seenSel;
  logic [1:0]  accessMode;
  logic [7:0]  qRd[$], ra[9] = '{8'hAA, 8'hAD, 8'hB0, 8'hB3, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'h10};
  logic [3:0]  qSel[$];
  int          qLen[$], n_fail = 0, n_checks = 0, cyc = 0, busyN = 0;
  always #10 ref_clk = ~ref_clk;
  csm_chip_select #(.PROT_STATES(4)) dut_u (.*);
  csm_ext_dev dev_u (.ref_clk, .rst_n, .selectActive_n, .seenSel);
  // compare and count
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // monitor: pops the oldest note as each result appears
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 6000) begin
      n_fail++;
      conclude();
    end
    if (rdP) chk("read data", qRd.pop_front(), regRdData);
    if (sP) chk("selects", {4'h0, qSel.pop_front()}, {4'h0, selectActive_n});
    if (accessBusy === 1'b1) busyN++;
    else if (busyN > 0) begin
      chk("busy length", 8'(qLen.pop_front()), 8'(busyN));
      busyN = 0;
    end
    rdP <= regRdEn;
    sP <= sReq;
  end
  // ----------------
  // bus tasks
  // ----------------
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    qRd.push_back(e);
    @(posedge ref_clk);
    regRdEn <= 1'b0;
  endtask
  task dec(input logic [23:0] a, input logic m, input logic i, input logic [3:0] e);
    @(posedge ref_clk);
    busAddr <= a;
    memReq <= m;
    ioReq <= i;
    sReq <= 1'b1;
    qSel.push_back(e);
    @(posedge ref_clk);
    {sReq, memReq, ioReq} <= 3'h0;
  endtask
  task acc(input logic [7:0] pro, input int e);
    wr(8'hF0, pro);
    memReq <= 1'b1;
    busAddr <= 24'h000000;
    @(posedge ref_clk);
    accessStart <= 1'b1;
    if (e > 0) qLen.push_back(e);
    @(posedge ref_clk);
    accessStart <= 1'b0;
    repeat (2) @(posedge ref_clk);
    while (accessBusy === 1'b1) @(posedge ref_clk);
    memReq <= 1'b0;
    chk("access mode", {6'h00, pro[7:6]}, {6'h00, accessMode});
    chk("shared addr data", {7'h00, pro[5]}, {7'h00, sharedAddrData});
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    void'($urandom(32'h138AD43D));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd(ra[i], i == 0 ? `CSM_CTL0_RST : (i > 3 && i < 8) ? `CSM_PRO_RST : 8'h00);
    $display("reset values done");
    for (int w = 0; w < 8; w++) begin
      wr(8'hAA, {w[2:0], 5'h08});
      acc(8'h02, w);
    end
    acc(8'h0F, 7);
    acc(8'h43, 12);
    acc(8'h82, 9);
    acc(8'h82, 8);
    acc(8'hC1, 5);
    acc(8'h6F, 60);
    $display("access timing done");
    for (int i = 0; i < 9; i++) begin
      d = 8'($urandom) | 8'h02;
      wr(ra[i], d);
      rd(ra[i], i < 4 ? d & 8'hF8 : i < 8 ? d & 8'hEF : 8'h00);
    end
    $display("register access done");
    wr(8'hAA, 8'h00);
    wr(8'hB3, 8'h00);
    wr(8'hAB, 8'h10);
    wr(8'hAC, 8'h20);
    wr(8'hAD, 8'h08);
    wr(8'hAE, 8'h42);
    wr(8'hAF, 8'h00);
    wr(8'hB0, 8'h18);
    dec(24'h100000, 1'b1, 1'b0, 4'hD);
    dec(24'h20FFFF, 1'b1, 1'b0, 4'hD);
    dec(24'h210000, 1'b1, 1'b0, 4'hF);
    dec(24'h0FFFFF, 1'b1, 1'b0, 4'hF);
    dec(24'h004200, 1'b0, 1'b1, 4'hB);
    dec(24'h004300, 1'b0, 1'b1, 4'hF);
    wr(8'hAD, 8'h00);
    dec(24'h150000, 1'b1, 1'b0, 4'hF);
    repeat (2) @(posedge ref_clk);
    chk("devices seen", 8'h07, {4'h0, seenSel});
    $display("decode done");
    conclude();
  end
endmodule
`default_nettype wire
